// file: include/ssf_defs.svh
// Offsets, field positions and reset values of the status flag block.
// Assumes inclusion by bare name from files under src/ and dv/.
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH
// Register byte offsets on the AXI4-Lite bus.
`define SSF_OFF_STATUS   8'h00
`define SSF_OFF_CONTROL  8'h04
`define SSF_OFF_IRQ_STAT 8'h08
`define SSF_OFF_IRQ_MASK 8'h0C
// Status field positions.
`define SSF_RXCNT_LSB    24
`define SSF_TXCNT_LSB    16
`define SSF_BIT_FRAME_ERR 12
`define SSF_BIT_ACT      11
`define SSF_BIT_TUR      8
`define SSF_BIT_SRE      7
`define SSF_BIT_ROV      6
`define SSF_BIT_RBE      5
`define SSF_BIT_TBE      3
`define SSF_BIT_TBF      1
`define SSF_BIT_RBF      0
// Control field positions.
`define SSF_BIT_EN       0
`define SSF_BIT_ENH      1
`define SSF_BIT_FRM      2
// Reset values and the interrupt event mask.
`define SSF_RST_CONTROL  3'h0
`define SSF_RST_TBE      1'h1
`define SSF_EVT_MASK     32'h0000_1140
// Bus responses.
`define SSF_RESP_OKAY    2'h0
`define SSF_RESP_SLVERR  2'h2
`endif

// file: include/ssf_pkg.sv
// Types shared by the status flag block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ssf_pkg;
  // Live state from the shifter and buffer datapath.
  typedef struct packed {
    logic [4:0] rx_count;     // Occupied receive elements.
    logic [4:0] tx_count;     // Occupied transmit elements.
    logic [4:0] rd_ptr;       // Receive FIFO read pointer.
    logic [4:0] wr_ptr;       // Receive FIFO write pointer.
    logic       frame_err;    // One-cycle framing error pulse.
    logic       busy;         // Transaction in progress.
    logic       underrun;     // One-cycle transmit underrun pulse.
    logic       shift_empty;  // Shift register holds no data.
    logic       rx_done;      // One-cycle word received pulse.
    logic       rx_unread;    // Previous word not yet read.
    logic       tx_empty;     // Transmit buffer empty.
    logic       tx_full;      // Transmit buffer full.
    logic       rx_full;      // Receive buffer full.
  } ssf_dp_t;
  // Control bits handed to the datapath.
  typedef struct packed {
    logic framed;    // Framed operation enabled.
    logic enhanced;  // Enhanced buffer mode.
    logic enable;    // Module enabled.
  } ssf_ctrl_t;
endpackage : ssf_pkg
`default_nettype wire

// file: src/ssf_status.sv
// Status flag register of the serial port with its AXI4-Lite slave.
// Assumes the datapath runs on aclk and the link pins are asynchronous.
//
// Contract
// [R01] Receive fill count at bits 28-24.
// [R02] Transmit fill count at bits 20-16.
// [R03] Frame error set by hardware, software clears.
// [R04] Activity flag high while transaction runs.
// [R05] Underrun flag, cleared by disable then enable.
// [R06] Shifter empty flag at bit 7.
// [R07] Overflow discards new word, sets bit 6.
// [R08] Overflow cleared only by writing zero.
// [R09] Receive empty when pointers are equal.
// [R10] Reset clears all, transmit empty reads one.
// [R11] Transmit and receive full flags bits 1,0.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`include "ssf_defs.svh"
`default_nettype none
module ssf_status (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  // AXI4-Lite write response.
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // AXI4-Lite read.
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // Datapath side.
  input  wire ssf_pkg::ssf_dp_t  dp,
  output var  ssf_pkg::ssf_ctrl_t ctrl,
  output var  logic              rx_discard,
  // Link pins.
  input  wire logic              sclk_pin,
  input  wire logic              ssel_n_pin,
  // Interrupt.
  output var  logic              irq
);

  // Expands byte strobes into a bit mask.
  function automatic logic [31:0] ssf_lanes(input logic [3:0] s);
    ssf_lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : ssf_lanes

  // Link synchronisers and edge finder.
  logic [2:0] sclk_s;      // Stage 0 feeds stage 1 only.
  logic [1:0] ssel_s;      // Stage 0 feeds stage 1 only.
  // Stored status flags.
  logic       fe_q;        // Frame error.
  logic       tur_q;       // Transmit underrun.
  logic       rov_q;       // Receive overflow.
  logic       act_q;       // Activity.
  logic       tbe_q;       // Transmit empty.
  logic [4:0] rxc_q;       // Receive count.
  logic [4:0] txc_q;       // Transmit count.
  logic       sre_q;       // Shifter empty.
  logic       rbe_q;       // Receive empty.
  logic       tbf_q;       // Transmit full.
  logic       rbf_q;       // Receive full.
  // Interrupt status and mask.
  logic [31:0] ist_q;
  logic [31:0] imask_q;
  // Latched write address and data.
  logic [7:0]  wa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;

  // Handshakes of the five channels.
  wire         aw_hs = awvalid & awready;
  wire         w_hs  = wvalid & wready;
  wire         b_hs  = bvalid & bready;
  wire         ar_hs = arvalid & arready;
  wire         r_hs  = rvalid & rready;
  // A write goes once both halves are in, whichever came last.
  wire         wr_go = (aw_hs | ~awready) & (w_hs | ~wready) & ~bvalid;
  wire [7:0]   wa    = aw_hs ? awaddr : wa_q;
  wire [31:0]  wd    = w_hs ? wdata : wd_q;
  wire [31:0]  wm    = ssf_lanes(w_hs ? wstrb : ws_q);
  // Register selects, decoded as an if chain would.
  wire         wr_st = wr_go & (wa == `SSF_OFF_STATUS);
  wire         wr_ct = wr_go & (wa == `SSF_OFF_CONTROL);
  wire         wr_is = wr_go & (wa == `SSF_OFF_IRQ_STAT);
  wire         wr_im = wr_go & (wa == `SSF_OFF_IRQ_MASK);
  wire         wr_ok = wr_st | wr_ct | wr_is | wr_im;

  // Link activity: selected, busy, or a clock edge just seen.
  wire         sclk_edge = sclk_s[2] ^ sclk_s[1];
  wire         next_act  = ~ssel_s[1] | dp.busy | sclk_edge; // [R04]
  // Hardware events; frame error and underrun gated by the modes that make them valid, overflow ungated.
  wire         fe_set  = dp.frame_err & ctrl.framed & ctrl.enable; // [R03]
  wire         tur_set = dp.underrun & ctrl.framed & ctrl.enable; // [R05]
  wire         ov_set  = dp.rx_done & dp.rx_unread; // [R07]
  // Software clears by writing zero under an enabled lane.
  wire         fe_clr  = wr_st & wm[`SSF_BIT_FRAME_ERR] & ~wd[`SSF_BIT_FRAME_ERR]; // [R03]
  wire         ov_clr  = wr_st & wm[`SSF_BIT_ROV] & ~wd[`SSF_BIT_ROV]; // [R08]
  // Disabling the module is what clears the underrun flag.
  wire         next_en = wr_ct & wm[`SSF_BIT_EN] ? wd[`SSF_BIT_EN] : ctrl.enable;
  wire         dis_go  = ctrl.enable & ~next_en; // [R05]
  // Event bits for the interrupt status, same layout as status.
  wire [31:0]  evt = ({31'h0, fe_set} << `SSF_BIT_FRAME_ERR)
                   | ({31'h0, tur_set} << `SSF_BIT_TUR)
                   | ({31'h0, ov_set} << `SSF_BIT_ROV);
  wire [31:0]  is_clr = wr_is ? (wd & wm) : 32'h0;
  wire [31:0]  next_ist = (evt | (ist_q & ~is_clr)) & `SSF_EVT_MASK;
  wire [31:0]  next_imask = wr_im ? ((wd & wm) | (imask_q & ~wm)) : imask_q;

  // Status word as software reads it; unused bits are zero.
  wire [31:0]  status_word = {3'h0, rxc_q, 3'h0, txc_q, 3'h0, fe_q, act_q,
                              2'h0, tur_q, sre_q, rov_q, rbe_q, 1'h0,
                              tbe_q, 1'h0, tbf_q, rbf_q};
  wire         rd_st = araddr == `SSF_OFF_STATUS;
  wire         rd_ct = araddr == `SSF_OFF_CONTROL;
  wire         rd_is = araddr == `SSF_OFF_IRQ_STAT;
  wire         rd_im = araddr == `SSF_OFF_IRQ_MASK;
  wire [31:0]  rd_val = rd_st ? status_word
                      : rd_ct ? {29'h0, ctrl}
                      : rd_is ? ist_q
                      : rd_im ? imask_q : 32'h0;
  wire         rd_ok = rd_st | rd_ct | rd_is | rd_im;

  // Synchronisers for the asynchronous link pins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_s <= 3'h0;
      ssel_s <= 2'h3;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk_pin};
      ssel_s <= {ssel_s[0], ssel_n_pin};
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fe_q  <= 1'h0; // [R10]
      tur_q <= 1'h0;
      rov_q <= 1'h0;
    end
    else
    begin
      fe_q  <= fe_set | (fe_q & ~fe_clr); // [R03]
      tur_q <= tur_set | (tur_q & ~dis_go); // [R05]
      rov_q <= ov_set | (rov_q & ~ov_clr); // [R07] [R08]
    end
  end

  // Live flags, registered so reset values hold at release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_q  <= 1'h0;
      tbe_q  <= `SSF_RST_TBE; // [R10]
      rxc_q  <= 5'h00;
      txc_q  <= 5'h00;
      sre_q  <= 1'h0;
      rbe_q  <= 1'h0;
      tbf_q  <= 1'h0;
      rbf_q  <= 1'h0;
    end
    else
    begin
      act_q  <= next_act; // [R04]
      tbe_q  <= dp.tx_empty;
      // Counts, shifter empty and receive empty mean nothing outside enhanced mode.
      rxc_q  <= ctrl.enhanced ? dp.rx_count : 5'h00; // [R01]
      txc_q  <= ctrl.enhanced ? dp.tx_count : 5'h00; // [R02]
      sre_q  <= ctrl.enhanced & dp.shift_empty; // [R06]
      rbe_q  <= ctrl.enhanced & (dp.rd_ptr == dp.wr_ptr); // [R09]
      tbf_q  <= dp.tx_full; // [R11]
      rbf_q  <= dp.rx_full; // [R11]
    end
  end

  // Discard strobe to the datapath on an overflowing word.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_discard <= 1'h0;
    else
      rx_discard <= ov_set; // [R07]
  end

  // Control register; software steers mode and enable here.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= `SSF_RST_CONTROL;
    else if (wr_ct)
      ctrl <= ssf_pkg::ssf_ctrl_t'((wd[2:0] & wm[2:0]) | (ctrl & ~wm[2:0]));
  end

  // Interrupt status, mask and level output.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ist_q   <= 32'h0000_0000;
      imask_q <= 32'h0000_0000;
      irq     <= 1'h0;
    end
    else
    begin
      ist_q   <= next_ist;
      imask_q <= next_imask;
      irq     <= |(next_ist & next_imask);
    end
  end

  // Write channel: each half taken once, released after the response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'h1;
      wready  <= 1'h1;
      bvalid  <= 1'h0;
      bresp   <= `SSF_RESP_OKAY;
      wa_q    <= 8'h00;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        awready <= 1'h0;
        wa_q    <= awaddr;
      end
      else if (b_hs)
        awready <= 1'h1;
      if (w_hs)
      begin
        wready <= 1'h0;
        wd_q   <= wdata;
        ws_q   <= wstrb;
      end
      else if (b_hs)
        wready <= 1'h1;
      if (wr_go)
      begin
        bvalid <= 1'h1;
        bresp  <= wr_ok ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
      end
      else if (b_hs)
        bvalid <= 1'h0;
    end
  end

  // Read channel: one read in flight, data sampled on address taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SSF_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready <= 1'h0;
      rvalid  <= 1'h1;
      rdata   <= rd_val;
      rresp   <= rd_ok ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
    end
    else if (r_hs)
    begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
    end
  end

  // Checks on the flag behaviour.
  default clocking ssf_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Overflow flag and the discard strobe that goes with it.
  chk_overflow_set_flag: assert property (ov_set |=> rov_q && rx_discard) // [R07]
    else $error("Overflow did not set flag and discard.");
  chk_discard_only_ovf: assert property ( // [R07]
    !ov_set |=> !rx_discard)
    else $error("Discard strobe without an overflow.");
  chk_overflow_one_write: assert property ( // [R08]
    rov_q && wr_st && wd[`SSF_BIT_ROV] |=> rov_q)
    else $error("Writing one cleared the overflow flag.");
  chk_overflow_zero_clear: assert property ( // [R08]
    rov_q && ov_clr && !ov_set |=> !rov_q)
    else $error("Writing zero did not clear overflow.");
  // Frame error is sticky and only appears in framed mode.
  chk_frame_error_set: assert property ( // [R03]
    fe_set |=> fe_q ##1 (fe_q || $past(fe_clr)))
    else $error("Frame error not held after detection.");
  chk_frame_needs_mode: assert property ( // [R03]
    !fe_q && !ctrl.framed |=> !fe_q)
    else $error("Frame error set outside framed mode.");
  chk_activity_follows: assert property ( // [R04]
    dp.busy |=> act_q)
    else $error("Activity flag low while busy.");
  // Underrun leaves only through a disable of the module.
  chk_underrun_disable: assert property ( // [R05]
    tur_q && dis_go && !tur_set |=> !tur_q)
    else $error("Underrun not cleared by disable.");
  chk_underrun_sticky: assert property ( // [R05]
    tur_q && !dis_go |=> tur_q)
    else $error("Underrun cleared without disable.");
  // Enhanced mode fields, full flags and reset values.
  chk_rx_empty_ptrs: assert property ( // [R09]
    ctrl.enhanced && $stable(ctrl) |=>
      rbe_q == ($past(dp.rd_ptr) == $past(dp.wr_ptr)))
    else $error("Receive empty does not match pointers.");
  chk_counts_field: assert property ( // [R01] [R02]
    rvalid && $rose(rvalid) && $past(rd_st) |->
      rdata[28:24] == $past(rxc_q) && rdata[20:16] == $past(txc_q))
    else $error("Counts not at their status fields.");
  chk_reset_tx_empty: assert property ( // [R10]
    $rose(aresetn) |-> tbe_q && !rov_q && !fe_q && !tur_q)
    else $error("Reset values of flags wrong.");
  chk_full_flags: assert property ( // [R11]
    1'b1 |=> tbf_q == $past(dp.tx_full) && rbf_q == $past(dp.rx_full))
    else $error("Full flags do not follow buffers.");
  chk_shifter_empty: assert property ( // [R06]
    !ctrl.enhanced ##1 !ctrl.enhanced |-> !sre_q)
    else $error("Shifter empty shown outside enhanced mode.");

  cov_overflow: cover property (ov_set ##[1:20] ov_clr);
  cov_underrun_cycle: cover property (tur_set ##[1:20] dis_go);
  cov_irq_raise: cover property ($rose(irq));
  cov_status_read: cover property (ar_hs && rd_st);

endmodule : ssf_status
`default_nettype wire

// file: dv/ssf_link_peer.sv
// Link peer model: one selected frame of sixteen serial clocks per request.
// Assumes the bench raises go to start a frame and waits for done.
`default_nettype none
module ssf_link_peer (
  // Frame request and completion.
  input  wire logic go,
  output var  logic done,
  // Serial pins; the clock idles low and stands still outside frames.
  output var  logic sclk_pin,
  output var  logic ssel_n_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Select, toggle the clock every 32 ns, then release the select line.
  initial
  begin
    sclk_pin = 1'h0;
    ssel_n_pin = 1'h1;
    done = 1'h0;
    forever
    begin
      @(posedge go);
      done = 1'h0;
      ssel_n_pin = 1'h0;
      repeat (16)
      begin
        #32 sclk_pin = 1'h1;
        #32 sclk_pin = 1'h0;
      end
      ssel_n_pin = 1'h1;
      done = 1'h1;
    end
  end
endmodule : ssf_link_peer
`default_nettype wire

// file: dv/spi_status_flags_bench.sv
// Bench of the serial port status block: bus tasks, flag events, link peer.
// Assumes the status block and peer model are compiled before this file.
`include "ssf_defs.svh"
`default_nettype none
module spi_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               aclk = 1'h0;     // Bus clock, 8 ns.
  logic               aresetn = 1'h0;  // Held low for 12 cycles.
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0]        wdata = 32'h0;
  logic [3:0]         wstrb = 4'hF;
  logic               awready, wready, bvalid, arready, rvalid, rx_discard, irq, sclk_pin, ssel_n_pin, done;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic               go = 1'h0;       // Starts one link frame.
  ssf_pkg::ssf_dp_t   dp = '0;         // Datapath state driven by the bench.
  ssf_pkg::ssf_ctrl_t ctrl;
  logic [65:0]        notes[$];        // Expected reads: mask, response, data.
  logic [65:0]        note;
  logic [2:0]         m_ctl = 3'h0;    // Model of the control register.
  logic               m_rov = 1'h0, m_fe = 1'h0, m_tur = 1'h0, m_act = 1'h0;
  logic [7:0]         lfsr = 8'h5F;
  int                 error_cnt = 0, checks = 0;
  // Free-running bus clock.
  always #4 aclk = ~aclk;
  ssf_status dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .dp(dp), .ctrl(ctrl), .rx_discard(rx_discard), .sclk_pin(sclk_pin),
    .ssel_n_pin(ssel_n_pin), .irq(irq));
  ssf_link_peer peer (.go(go), .done(done), .sclk_pin(sclk_pin), .ssel_n_pin(ssel_n_pin));
  // Pseudo-random source, seeded at 95.
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  // Expected status word from the flag model and the present datapath state.
  function automatic logic [31:0] exp_stat();
    logic [31:0] s;
    s = 32'h0;
    if (m_ctl[1])
    begin
      s[28:24] = dp.rx_count;
      s[20:16] = dp.tx_count;
      s[7] = dp.shift_empty;
      s[5] = dp.rd_ptr == dp.wr_ptr;
    end
    s[12] = m_fe;
    s[11] = m_act;
    s[8] = m_tur;
    s[6] = m_rov;
    s[3] = dp.tx_empty;
    s[1] = dp.tx_full;
    s[0] = dp.rx_full;
    return s;
  endfunction : exp_stat
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Read monitor: takes the oldest note whenever a read answer is accepted.
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      note = notes.pop_front();
      chk("read data", note[31:0] & note[65:34], rdata & note[65:34]);
      chk("read response", {30'h0, note[33:32]}, {30'h0, rresp});
    end
  end
  // One write; address and data are released each at its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready)
      begin
        chk("write response", {30'h0, resp}, {30'h0, bresp});
        bready <= 1'h0;
        break;
      end
    end
  endtask : wr
  // One read; the expectation is noted before the request goes out.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] resp, input logic [31:0] e);
    notes.push_back({m, resp, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready)
      begin
        rready <= 1'h0;
        break;
      end
    end
  endtask : rd
  // Status read against the model.
  task automatic st();
    rd(`SSF_OFF_STATUS, 32'hFFFF_FFFF, `SSF_RESP_OKAY, exp_stat());
  endtask : st
  // Control write; dropping enable clears the underrun model.
  task automatic setctl(input logic [2:0] v);
    wr(`SSF_OFF_CONTROL, {29'h0, v}, 4'hF, `SSF_RESP_OKAY);
    chk("control", {29'h0, v}, {29'h0, ctrl});
    if (m_ctl[0] && !v[0]) m_tur = 1'h0;
    m_ctl = v;
  endtask : setctl
  // One-cycle event pulses {underrun, frame error, word done}, then the discard check.
  task automatic ev(input logic [2:0] sel, input logic unread);
    @(posedge aclk);
    dp.underrun <= sel[2];
    dp.frame_err <= sel[1];
    dp.rx_done <= sel[0];
    dp.rx_unread <= unread;
    @(posedge aclk);
    dp.underrun <= 1'h0;
    dp.frame_err <= 1'h0;
    dp.rx_done <= 1'h0;
    #1;
    chk("discard", {31'h0, sel[0] & unread}, {31'h0, rx_discard});
    m_rov = m_rov | (sel[0] & unread);
    m_fe = m_fe | (sel[1] & m_ctl[2] & m_ctl[0]);
    m_tur = m_tur | (sel[2] & m_ctl[2] & m_ctl[0]);
  endtask : ev
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    logic [7:0] r;
    dp.tx_empty = 1'h1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SSF_OFF_STATUS, 32'hFFFF_FFFF, `SSF_RESP_OKAY, 32'h0000_0008);
    rd(`SSF_OFF_CONTROL, 32'hFFFF_FFFF, `SSF_RESP_OKAY, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF, 4'hF, `SSF_RESP_SLVERR);
    rd(8'h40, 32'h0, `SSF_RESP_SLVERR, 32'h0);
    $display("test reset done");
    // Random fill counts, pointers and levels, with enhanced mode on then off.
    for (int e = 1; e >= 0; e--)
    begin
      setctl({1'h0, e[0], 1'h1});
      for (int i = 0; i < 3; i++)
      begin
        @(posedge aclk);
        r = rnd();
        dp.rx_count <= r[4:0];
        dp.shift_empty <= r[5];
        dp.tx_full <= r[6];
        dp.rx_full <= r[7];
        r = rnd();
        dp.tx_count <= r[4:0];
        dp.rd_ptr <= r[4:0];
        dp.wr_ptr <= r[4:0] ^ {4'h0, r[7]};
        dp.tx_empty <= r[5];
        #1;
        st();
      end
    end
    $display("test fields done");
    // Overflow only when the previous word is unread; the interrupt follows the mask.
    wr(`SSF_OFF_IRQ_MASK, 32'h40, 4'hF, `SSF_RESP_OKAY);
    ev(3'h1, 1'h0);
    st();
    ev(3'h1, 1'h1);
    @(posedge aclk);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    rd(`SSF_OFF_IRQ_STAT, 32'hFFFF_FFFF, `SSF_RESP_OKAY, 32'h40);
    wr(`SSF_OFF_STATUS, 32'hFFFF_FFFF, 4'hF, `SSF_RESP_OKAY);
    st();
    wr(`SSF_OFF_STATUS, 32'h0, 4'h1, `SSF_RESP_OKAY);
    m_rov = 1'h0;
    st();
    wr(`SSF_OFF_IRQ_STAT, 32'h40, 4'hF, `SSF_RESP_OKAY);
    @(posedge aclk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    $display("test overflow done");
    // Frame error and underrun need framed mode; each has its own way out.
    wr(`SSF_OFF_IRQ_MASK, 32'h0, 4'hF, `SSF_RESP_OKAY);
    ev(3'h6, 1'h0);
    st();
    setctl(3'h5);
    ev(3'h6, 1'h0);
    st();
    chk("irq", 32'h0, {31'h0, irq});
    wr(`SSF_OFF_STATUS, 32'h0, 4'h3, `SSF_RESP_OKAY);
    m_fe = 1'h0;
    st();
    setctl(3'h4);
    setctl(3'h5);
    st();
    rd(`SSF_OFF_IRQ_STAT, 32'hFFFF_FFFF, `SSF_RESP_OKAY, 32'h1100);
    wr(`SSF_OFF_IRQ_STAT, 32'h1100, 4'hF, `SSF_RESP_OKAY);
    rd(`SSF_OFF_IRQ_STAT, 32'hFFFF_FFFF, `SSF_RESP_OKAY, 32'h0);
    $display("test framed done");
    // Activity from the datapath busy level, then from a link frame.
    @(posedge aclk);
    dp.busy <= 1'h1;
    repeat (3) @(posedge aclk);
    m_act = 1'h1;
    st();
    dp.busy <= 1'h0;
    go <= 1'h1;
    repeat (10) @(posedge aclk);
    st();
    while (done !== 1'h1) @(posedge aclk);
    go <= 1'h0;
    repeat (8) @(posedge aclk);
    m_act = 1'h0;
    st();
    $display("test activity done");
    give_verdict();
  end
endmodule : spi_status_flags_bench
`default_nettype wire
